// file: logic/ehc_defs.svh
// constants for the ethernet header comparator: register offsets, resets, protocol values
//
// Operation
// - two comparators per engine; the first always sits in stage one
// - type II accepts zero to two tags, S-tag or C-tag by TPID
// - byte after the final EtherType starts the next protocol
// - a length needs LLC with DSAP/SSAP 0xAA or 0xAB and control 0x03
// - a five-byte SNAP header of OUI and EtherType follows LLC
// - SNAP OUI must be zero or 0xf8, fixed in hardware
// - a tag EtherType in SNAP is followed by its tag control field
// - longest header: two tags, length, LLC and SNAP
// - backbone frames split over two consecutive comparators, first ends at I-tag
// - one shared next-protocol check plus per-flow match sets, both evaluated
// - next-protocol check examines the last EtherType
// - three-bit field selects the next comparator stage
// - five-bit field gives the frame signature start offset
// - one global 16-bit TPID recognises S-tags and B-tags
// - backbone enable exists only in the first comparator
// - EtherType match applies only to type II frames when enabled
// - flows combine tag checks with address matching over several sets; the code matches only enable, channel and tag count, with no address fields
// - a flow joins a channel only when that channel bit is 1
// - two-bit field sets expected tag count zero, one or two
// - length/type below 0x0600 is a length needing LLC and SNAP
`ifndef EHC_DEFS_SVH
`define EHC_DEFS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define EHC_OFS_NXT      12'h000
`define EHC_OFS_TPID     12'h004
`define EHC_OFS_ETYPE    12'h008
`define EHC_OFS_FLOW     12'h00C
`define EHC_OFS_STATUS   12'h010

// ****************************************
// reset values and field positions
// ****************************************
`define EHC_RST_TPID     16'h88A8
`define EHC_RST_NXT      3'h1
`define EHC_NXT_SIG_LSB  8
`define EHC_NXT_PBB_BIT  16
`define EHC_ETYPE_EN_BIT 16

// ****************************************
// protocol constants
// ****************************************
`define EHC_CTAG_TPID    16'h8100
`define EHC_ITAG_TPID    16'h88E7
`define EHC_LEN_LIMIT    16'h0600
`define EHC_SAP_A        8'hAA
`define EHC_SAP_B        8'hAB
`define EHC_LLC_CTL      8'h03
`define EHC_OUI_ALT      24'h0000F8
`define EHC_NFLOW        8
`define EHC_NCHAN        2
`define EHC_MAXHDR       32

`endif

// file: logic/ehc_pkg.sv
// types shared by the ethernet header comparator files
`default_nettype none
package ehc_pkg;
	typedef enum logic [2:0] {
		EHC_IDLE  = 3'h0,
		EHC_LOAD  = 3'h1,
		EHC_PARSE = 3'h3,
		EHC_DONE  = 3'h2
	} ehc_state_e;

	typedef struct packed {
		logic       valid;
		logic [2:0] next_stage;
		logic [5:0] next_offset;
		logic [4:0] sig_offset;
		logic       proto_ok;
		logic [7:0] flow_hits;
	} ehc_result_s;

	typedef struct packed {
		logic       en;
		logic [1:0] chan;
		logic [1:0] tags;
	} ehc_flow_s;
endpackage : ehc_pkg
`default_nettype wire

// file: logic/ehc_apb.sv
// apb slave port decoding for the comparator registers
`include "ehc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ehc_apb
	import ehc_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// apb
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// register side
	output logic             wr_nxt,
	output logic             wr_tpid,
	output logic             wr_etype,
	output logic             wr_flow,
	input  wire logic [31:0] rd_nxt,
	input  wire logic [31:0] rd_tpid,
	input  wire logic [31:0] rd_etype,
	input  wire logic [31:0] rd_flow,
	input  wire logic [31:0] rd_status
);
	logic        acc;
	logic        hit;
	logic [31:0] rmux;

	// zero wait state: every access completes in its first access cycle
	assign acc    = psel & penable;
	assign pready = psel & penable;

	// address decode
	always_comb begin
		hit  = 1'b1;
		rmux = 32'h0000_0000;
		if (paddr == `EHC_OFS_NXT) begin
			rmux = rd_nxt;
		end else if (paddr == `EHC_OFS_TPID) begin
			rmux = rd_tpid;
		end else if (paddr == `EHC_OFS_ETYPE) begin
			rmux = rd_etype;
		end else if (paddr == `EHC_OFS_FLOW) begin
			rmux = rd_flow;
		end else if (paddr == `EHC_OFS_STATUS) begin
			rmux = rd_status;
		end else begin
			hit = 1'b0;
		end
	end

	assign pslverr  = acc & ~hit;
	assign wr_nxt   = acc & pwrite & (paddr == `EHC_OFS_NXT);
	assign wr_tpid  = acc & pwrite & (paddr == `EHC_OFS_TPID);
	assign wr_etype = acc & pwrite & (paddr == `EHC_OFS_ETYPE);
	assign wr_flow  = acc & pwrite & (paddr == `EHC_OFS_FLOW);

	// read data is registered so it stays stable; captured during setup
	always_ff @(posedge clk) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
		end else if (psel & ~penable & ~pwrite) begin
			prdata <= rmux;
		end
	end
endmodule : ehc_apb
`default_nettype wire

// file: logic/ehc_flow.sv
// per-flow matcher: enable, channel mask and tag count
`include "ehc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ehc_flow
	import ehc_pkg::*;
(
	// flow configuration
	input  wire ehc_flow_s [`EHC_NFLOW-1:0] cfg,
	// frame facts
	input  wire logic                       chan,
	input  wire logic [1:0]                 tag_cnt,
	// results
	output logic      [`EHC_NFLOW-1:0]      hits
);
	// address and tag value fields are not carried; tag count is the only tag check
	always_comb begin
		for (int i = 0; i < `EHC_NFLOW; i++) begin
			hits[i] = cfg[i].en
				& cfg[i].chan[chan]
				& (cfg[i].tags == tag_cnt);
		end
	end
endmodule : ehc_flow
`default_nettype wire

// file: logic/ehc_top.sv
// ethernet / llc / snap header comparator stage with apb registers
//
// Local design decisions: the placing of the registers and the APB slave port.
`include "ehc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ehc_top
	import ehc_pkg::*;
#(
	parameter bit FIRST = 1'b1 // first comparator of the engine
)(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// apb
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// header bytes from the engine controller, one per cycle
	input  wire logic        hdr_start,
	input  wire logic        hdr_valid,
	input  wire logic [7:0]  hdr_byte,
	input  wire logic        hdr_chan,
	input  wire logic        type1_allowed,
	// result to the next comparator
	output ehc_result_s      result
);
	// ****************************************
	// configuration registers
	// ****************************************
	logic [2:0]  next_stage_select_q;
	logic [4:0]  signature_field_offset_q;
	logic        backbone_bridging_enable_q;
	logic [15:0] service_tag_tpid_q;
	logic        ethertype_check_enable_q;
	logic [15:0] ethertype_match_value_q;
	ehc_flow_s [`EHC_NFLOW-1:0] flow_q;
	logic [39:0] flow_bits;      // flat view of the flow table for readback
	logic        wr_nxt, wr_tpid, wr_etype, wr_flow;
	logic [31:0] status;

	ehc_apb u_apb (
		.clk      (clk),
		.reset    (reset),
		.psel     (psel),
		.penable  (penable),
		.pwrite   (pwrite),
		.paddr    (paddr),
		.pwdata   (pwdata),
		.prdata   (prdata),
		.pready   (pready),
		.pslverr  (pslverr),
		.wr_nxt   (wr_nxt),
		.wr_tpid  (wr_tpid),
		.wr_etype (wr_etype),
		.wr_flow  (wr_flow),
		.rd_nxt   ({15'h0000, backbone_bridging_enable_q, 3'h0,
			signature_field_offset_q, 5'h00, next_stage_select_q}),
		.rd_tpid  ({16'h0000, service_tag_tpid_q}),
		.rd_etype ({15'h0000, ethertype_check_enable_q, ethertype_match_value_q}),
		.rd_flow  ({8'h00, flow_bits[23:0]}),
		.rd_status(status)
	);

	// next-protocol registers
	always_ff @(posedge clk) begin
		if (reset) begin
			next_stage_select_q        <= `EHC_RST_NXT;
			signature_field_offset_q   <= 5'h00;
			backbone_bridging_enable_q <= 1'b0;
		end else if (wr_nxt) begin
			next_stage_select_q      <= pwdata[2:0];
			signature_field_offset_q <= pwdata[`EHC_NXT_SIG_LSB +: 5];
			// only the first comparator keeps the bridging bit
			backbone_bridging_enable_q <= FIRST & pwdata[`EHC_NXT_PBB_BIT];
		end
	end

	// global tag identifier
	always_ff @(posedge clk) begin
		if (reset) begin
			service_tag_tpid_q <= `EHC_RST_TPID;
		end else if (wr_tpid) begin
			service_tag_tpid_q <= pwdata[15:0];
		end
	end

	// ethertype match
	always_ff @(posedge clk) begin
		if (reset) begin
			ethertype_check_enable_q <= 1'b0;
			ethertype_match_value_q  <= 16'h0000;
		end else if (wr_etype) begin
			ethertype_check_enable_q <= pwdata[`EHC_ETYPE_EN_BIT];
			ethertype_match_value_q  <= pwdata[15:0];
		end
	end

	// flow table; flows 0 to 3 fit in one bus word, flow 4 takes chan and tags from pwdata[23:20] with en cleared, the rest stay cleared
	assign flow_bits = flow_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			flow_q <= '0;
		end else if (wr_flow) begin
			flow_q <= {16'h0000, pwdata[23:0]};
		end
	end

	// ****************************************
	// header parser
	// ****************************************
	ehc_state_e  st_q;
	logic [5:0]  pos_q;          // bytes consumed so far
	logic [15:0] word_q;         // last two bytes
	logic [23:0] oui_q;
	logic [1:0]  tags_q;
	logic        llc_q;          // llc/snap path taken
	logic [5:0]  fld_q;          // start of pending two-byte field
	logic [2:0]  kind_q;         // what the pending field is
	logic        bad_q;
	logic        type2_q;
	logic [15:0] etype_q;
	logic [5:0]  next_q;
	logic        pbb_done_q;
	logic [15:0] w;

	localparam logic [2:0] K_TYPE = 3'h0, K_TCI = 3'h1, K_LLC = 3'h2,
		K_SNAP = 3'h3, K_ITAG = 3'h4, K_END = 3'h5;

	assign w = {word_q[7:0], hdr_byte};

	// is this a tag identifier we know
	function automatic logic is_tag(input logic [15:0] v, input logic [15:0] stpid);
		is_tag = (v == `EHC_CTAG_TPID) | (v == stpid);
	endfunction : is_tag

	// state and byte walk; one byte per valid cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			st_q       <= EHC_IDLE;
			pos_q      <= 6'h00;
			word_q     <= 16'h0000;
			oui_q      <= 24'h000000;
			tags_q     <= 2'h0;
			llc_q      <= 1'b0;
			fld_q      <= 6'd12;
			kind_q     <= K_TYPE;
			bad_q      <= 1'b0;
			type2_q    <= 1'b0;
			etype_q    <= 16'h0000;
			next_q     <= 6'h00;
			pbb_done_q <= 1'b0;
		end else begin
			case (st_q)
				EHC_IDLE, EHC_DONE: begin
					if (hdr_start) begin
						st_q       <= EHC_LOAD;
						pos_q      <= 6'h00;
						tags_q     <= 2'h0;
						llc_q      <= 1'b0;
						fld_q      <= 6'd12;
						kind_q     <= K_TYPE;
						bad_q      <= 1'b0;
						type2_q    <= 1'b0;
						pbb_done_q <= 1'b0;
					end
				end
				EHC_LOAD, EHC_PARSE: begin
					if (hdr_valid) begin
						st_q   <= EHC_PARSE;
						word_q <= w;
						pos_q  <= pos_q + 6'h01;
						if (llc_q && kind_q == K_SNAP && pos_q < fld_q) begin
							oui_q <= {oui_q[15:0], hdr_byte};
						end
						if (pos_q == fld_q + 6'h01) begin
							case (kind_q)
								K_TYPE: begin
									if (is_tag(w, service_tag_tpid_q) && tags_q != 2'h2
										&& !(backbone_bridging_enable_q && tags_q == 2'h1)) begin
										kind_q <= K_TCI;
										fld_q  <= pos_q + 6'h01;
										tags_q <= tags_q + 2'h1;
									end else if (backbone_bridging_enable_q
										&& w == `EHC_ITAG_TPID) begin
										// first comparator stops after the I-tag
										kind_q     <= K_ITAG;
										fld_q      <= pos_q + 6'h03;
										pbb_done_q <= 1'b1;
									end else if (type1_allowed && w < `EHC_LEN_LIMIT
										&& !llc_q && !backbone_bridging_enable_q) begin
										kind_q <= K_LLC;
										fld_q  <= pos_q + 6'h01;
										llc_q  <= 1'b1;
									end else begin
										// final ethertype: next byte starts next protocol
										etype_q <= w;
										type2_q <= ~llc_q;
										next_q  <= pos_q + 6'h01;
										st_q    <= EHC_DONE;
										bad_q   <= bad_q | (backbone_bridging_enable_q
											& ~pbb_done_q);
									end
								end
								K_TCI: begin
									kind_q <= K_TYPE;
									fld_q  <= pos_q + 6'h01;
								end
								K_ITAG: begin
									next_q <= pos_q + 6'h01;
									st_q   <= EHC_DONE;
								end
								default: begin
									// llc: dsap,ssap then ctrl byte
									if (!((word_q[7:0] == `EHC_SAP_A || word_q[7:0] == `EHC_SAP_B)
										&& (hdr_byte == `EHC_SAP_A || hdr_byte == `EHC_SAP_B))
										&& kind_q == K_LLC) begin
										bad_q <= 1'b1;
									end
									if (kind_q == K_LLC) begin
										// control byte and three oui bytes precede the snap ethertype
										kind_q <= K_SNAP;
										fld_q  <= pos_q + 6'h05;
									end else begin
										// snap ethertype; a tag here loops to tci
										if (!(oui_q == 24'h000000 || oui_q == `EHC_OUI_ALT)) begin
											bad_q <= 1'b1;
										end
										if (is_tag(w, service_tag_tpid_q) && tags_q != 2'h2) begin
											kind_q <= K_TCI;
											tags_q <= tags_q + 2'h1;
										end else begin
											kind_q <= K_END;
										end
										fld_q <= pos_q + 6'h01;
										if (!is_tag(w, service_tag_tpid_q) || tags_q == 2'h2) begin
											etype_q <= w;
											next_q  <= pos_q + 6'h01;
											st_q    <= EHC_DONE;
										end
									end
								end
							endcase
						end else if (kind_q == K_SNAP && pos_q == fld_q - 6'h04
							&& hdr_byte != `EHC_LLC_CTL) begin
							bad_q <= 1'b1;
						end
						if (pos_q == 6'(`EHC_MAXHDR + 4)) begin
							bad_q <= 1'b1;
							st_q  <= EHC_DONE;
						end
					end
				end
				default: st_q <= EHC_IDLE;
			endcase
		end
	end

	// llc control byte sits one past the sap pair; it is checked at fld_q - 4 once fld_q points at the snap ethertype
	// ****************************************
	// result
	// ****************************************
	logic [`EHC_NFLOW-1:0] hits;
	logic                  proto_ok;
	logic                  done_q;

	ehc_flow u_flow (
		.cfg     (flow_q),
		.chan    (hdr_chan),
		.tag_cnt (tags_q),
		.hits    (hits)
	);

	// shared check and per-flow check are both evaluated for the frame
	assign proto_ok = ~bad_q & (~ethertype_check_enable_q | ~type2_q
		| (etype_q == ethertype_match_value_q));

	always_ff @(posedge clk) begin
		if (reset) begin
			done_q <= 1'b0;
			result <= '0;
		end else begin
			done_q       <= (st_q == EHC_DONE);
			result.valid <= (st_q == EHC_DONE) & ~done_q;
			if (st_q == EHC_DONE && !done_q) begin
				result.next_stage  <= next_stage_select_q;
				result.next_offset <= next_q;
				result.sig_offset  <= signature_field_offset_q;
				result.proto_ok    <= proto_ok;
				result.flow_hits   <= hits & {`EHC_NFLOW{proto_ok}};
			end
		end
	end

	assign status = {22'h000000, tags_q, type2_q, bad_q, 2'h0, st_q, FIRST};

	// ****************************************
	// checks
	// ****************************************
	property p_second_no_pbb;
		@(posedge clk) disable iff (reset) !FIRST |-> !backbone_bridging_enable_q;
	endproperty
	a_second_no_pbb: assert property (p_second_no_pbb) else $error("bridging in second");

	property p_disabled_flow;
		@(posedge clk) disable iff (reset) result.valid |-> ((result.flow_hits & ~hits) == 0);
	endproperty
	a_disabled_flow: assert property (p_disabled_flow) else $error("flow hit mismatch");

	property p_valid_pulse;
		@(posedge clk) disable iff (reset) result.valid |=> !result.valid;
	endproperty
	a_valid_pulse: assert property (p_valid_pulse) else $error("result valid too long");

	property p_tag_limit;
		@(posedge clk) disable iff (reset) tags_q != 2'h3;
	endproperty
	a_tag_limit: assert property (p_tag_limit) else $error("more than two tags");

	property p_llc_not_type2;
		@(posedge clk) disable iff (reset) (st_q == EHC_DONE && llc_q) |-> !type2_q;
	endproperty
	a_llc_not_type2: assert property (p_llc_not_type2) else $error("llc frame as type two");

	property p_hits_need_ok;
		@(posedge clk) disable iff (reset)
			(result.valid && !result.proto_ok) |-> (result.flow_hits == 8'h00);
	endproperty
	a_hits_need_ok: assert property (p_hits_need_ok) else $error("flow hit without protocol");
endmodule : ehc_top
`default_nettype wire

// file: test/ehc_eng_model.sv
// engine controller model: hands header bytes to the comparator, one per cycle
`timescale 1ns/1ps
`default_nettype none
module ehc_eng_model (
	// clock
	input  wire logic       clk,
	// header stream to the comparator
	output logic            hdr_start,
	output logic            hdr_valid,
	output logic [7:0]      hdr_byte,
	output logic            hdr_chan,
	output logic            type1_allowed
);
	// idle values from time zero
	initial begin
		hdr_start     = 1'b0;
		hdr_valid     = 1'b0;
		hdr_byte      = 8'h00;
		hdr_chan      = 1'b0;
		type1_allowed = 1'b0;
	end

	// start pulse on its own cycle, then the bytes back to back
	task automatic send(input logic [7:0] q[$], input logic ch, input logic t1);
		@(posedge clk);
		hdr_start     <= 1'b1;
		hdr_chan      <= ch;
		type1_allowed <= t1;
		@(posedge clk);
		hdr_start <= 1'b0;
		foreach (q[i]) begin
			hdr_valid <= 1'b1;
			hdr_byte  <= q[i];
			@(posedge clk);
		end
		// released data line shows no stale byte, so a late sample cannot pass by luck
		hdr_valid <= 1'b0;
		hdr_byte  <= ~q[q.size()-1];
	endtask : send
endmodule : ehc_eng_model
`default_nettype wire

// file: test/ethernet_snap_llc_header_comparator_tb_top.sv
// self-checking bench for the header comparator: apb tasks and frame scenarios
`include "ehc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (g), (e)); end end
module ethernet_snap_llc_header_comparator_tb_top
	import ehc_pkg::*;
;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        hdr_start;
	logic        hdr_valid;
	logic [7:0]  hdr_byte;
	logic        hdr_chan;
	logic        type1_allowed;
	ehc_result_s result;
	int          bad_count = 0;
	int          checks_done = 0;
	logic [31:0] rd;
	logic        err;

	always #2.5 clk = ~clk;

	ehc_top #(.FIRST(1'b1)) u_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hdr_start(hdr_start), .hdr_valid(hdr_valid), .hdr_byte(hdr_byte),
		.hdr_chan(hdr_chan), .type1_allowed(type1_allowed), .result(result));

	ehc_eng_model u_eng (.clk(clk), .hdr_start(hdr_start), .hdr_valid(hdr_valid),
		.hdr_byte(hdr_byte), .hdr_chan(hdr_chan), .type1_allowed(type1_allowed));

	// ****************************************
	// tasks
	// ****************************************
	// leading edge keeps a release and the next setup out of one time step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic finish_test();
		if (bad_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test

	// flow 0 enabled on channel 0, flow 1 the same but disabled; ehit 8'hFF marks a refusal
	task automatic run(input logic [1:0] nt, input logic [15:0] tp, input logic snap,
		input logic [7:0] ctl, input logic [15:0] et, input logic ch, input logic t1,
		input logic [5:0] eofs, input logic eok, input logic [7:0] ehit);
		logic [7:0]  q[$];
		ehc_result_s r;
		logic        got;
		int          n;
		int          m;
		got = 1'b0;
		apb(1'b1, `EHC_OFS_FLOW, {22'h0, 1'b0, 2'b01, nt, 1'b1, 2'b01, nt}, rd, err);
		for (n = 0; n < 12; n++) q.push_back(8'h10 + n[7:0]);
		for (n = 0; n < nt; n++) begin
			q.push_back(n == 0 ? tp[15:8] : 8'h81);
			q.push_back(n == 0 ? tp[7:0] : 8'h00);
			q.push_back(8'h00);
			q.push_back(8'h05 + n[7:0]);
		end
		if (snap) begin
			q = {q, 8'h00, 8'h40, `EHC_SAP_A, `EHC_SAP_B, ctl, 8'h00, 8'h00, 8'h00};
		end
		q = {q, et[15:8], et[7:0]};
		fork
			u_eng.send(q, ch, t1);
			for (m = 0; m < 100 && !got; m++) begin
				@(posedge clk);
				if (result.valid === 1'b1) begin
					r = result;
					got = 1'b1;
				end
			end
		join
		`CHK(got, 1'b1)
		`CHK(r.proto_ok, eok)
		if (ehit !== 8'hFF) begin
			`CHK(r.next_offset, eofs)
			`CHK(r.next_stage, 3'h5)
			`CHK(r.sig_offset, 5'h1F)
			`CHK(r.flow_hits, ehit)
		end
	endtask : run

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		apb(1'b0, `EHC_OFS_TPID, 32'h0, rd, err);
		`CHK(rd, {16'h0, `EHC_RST_TPID})
		apb(1'b0, `EHC_OFS_NXT, 32'h0, rd, err);
		`CHK(rd, {29'h0, `EHC_RST_NXT})
		apb(1'b1, `EHC_OFS_NXT, 32'h0001_1F05, rd, err);
		apb(1'b0, `EHC_OFS_NXT, 32'h0, rd, err);
		`CHK(rd, 32'h0001_1F05)
		apb(1'b1, `EHC_OFS_NXT, 32'h0000_1F05, rd, err);
		apb(1'b1, `EHC_OFS_ETYPE, 32'h0001_88F7, rd, err);
		apb(1'b0, `EHC_OFS_ETYPE, 32'h0, rd, err);
		`CHK(rd, 32'h0001_88F7)
		apb(1'b1, 12'h020, 32'hFFFF_FFFF, rd, err);
		`CHK(err, 1'b1)
		apb(1'b0, `EHC_OFS_NXT, 32'h0, rd, err);
		`CHK(rd, 32'h0000_1F05)
		// type II: match, mismatch, tags by default and programmed identifiers
		run(2'd0, 16'h0, 1'b0, 8'h03, 16'h88F7, 1'b0, 1'b0, 6'd14, 1'b1, 8'h01);
		run(2'd0, 16'h0, 1'b0, 8'h03, 16'h0800, 1'b0, 1'b0, 6'd14, 1'b0, 8'h00);
		run(2'd1, `EHC_CTAG_TPID, 1'b0, 8'h03, 16'h88F7, 1'b0, 1'b0, 6'd18, 1'b1, 8'h01);
		run(2'd1, `EHC_RST_TPID, 1'b0, 8'h03, 16'h88F7, 1'b0, 1'b0, 6'd18, 1'b1, 8'h01);
		apb(1'b1, `EHC_OFS_TPID, 32'h0000_9100, rd, err);
		run(2'd2, 16'h9100, 1'b0, 8'h03, 16'h88F7, 1'b0, 1'b0, 6'd22, 1'b1, 8'h01);
		run(2'd0, 16'h0, 1'b0, 8'h03, 16'h88F7, 1'b1, 1'b0, 6'd14, 1'b1, 8'h00);
		// length frames: llc and snap, longest header, bad control, length not allowed
		run(2'd0, 16'h0, 1'b1, 8'h03, 16'h88F7, 1'b0, 1'b1, 6'd22, 1'b1, 8'h01);
		run(2'd2, 16'h9100, 1'b1, 8'h03, 16'h88F7, 1'b0, 1'b1, 6'd30, 1'b1, 8'h01);
		run(2'd0, 16'h0, 1'b1, 8'h04, 16'h88F7, 1'b0, 1'b1, 6'd22, 1'b0, 8'hFF);
		run(2'd0, 16'h0, 1'b1, 8'h03, 16'h88F7, 1'b0, 1'b0, 6'd14, 1'b0, 8'h00);
		finish_test();
	end

	// watchdog at 20000 cycles, far beyond the few hundred cycles the scenarios need
	initial begin
		#100000;
		bad_count++;
		finish_test();
	end
endmodule : ethernet_snap_llc_header_comparator_tb_top
`default_nettype wire
